// *** design/ast_serial_tx.sv ***
// Asynchronous serial transmitter with APB registers and pin ownership
//
// Function
// [R1] Idle transmit line rests at mark, logic one.
// [R2] Frame is one start bit, eight or nine data bits, stop bit.
// [R3] Each bit lasts exactly one baud period.
// [R4] Data bits leave least significant first.
// [R5] Transmitter and receiver share one format and baud setting.
// [R6] No hardware parity; software puts it in the ninth bit.
// [R7] Bit timing from 8-bit or 16-bit divisor baud generator.
// [R8] Sending only with transmit enable, async mode and port enable.
// [R9] Port enable forces transmit pin to driven serial output.
// [R10] Port enable forces receive pin input, readable, latch blocked.
// [R11] Data write starts sending; empty shifter loads at once.
// [R12] Busy shifter: character waits for stop end, then starts.
// [R13] Empty flag set when enabled and holding register free.
// [R14] Empty flag sets as soon as transmit enable is set.
// [R15] Empty flag valid in second instruction cycle after write.
// [R16] Empty flag is read only.
// [R17] Flag ignores enables; interrupt needs flag and three enables.
// [R18] Shifter-empty status clears on load, sets when all sent.
// [R19] Nine-bit mode sends ninth bit as MSB, captured at write.
// [R20] Software sets ninth bit to mark an address character.
// [R21] Software enables empty interrupt only while data remains.
// [R22] Software sets baud, port, mode, enable, ninth bit, then data.
// [R23] One stop bit, then mark idle when nothing pending.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ast_serial_tx
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit pin
  input wire logic transmitPinLatch,
  input wire logic transmitPinDirection,
  output logic transmitPinOut,
  output logic transmitPinOe,
  // Receive pin
  input wire logic receivePinIn,
  input wire logic receivePinLatch,
  input wire logic receivePinDirection,
  output logic receivePinOut,
  output logic receivePinOe,
  output logic receivePinLevel,
  // Shared with the receiver, plus the empty interrupt
  output logic [15:0] baudDivisor,
  output logic nineBitSelect,
  output logic transmitEmptyIrq
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] baud_q;
  logic [IRQEN_W-1:0] irqEn_q;
  logic [CHAR_W-1:0] holdData_q;
  logic holdFull_q;
  logic charNine_q;
  logic shiftNine_q;
  logic [3:0] bitCnt_q;
  logic [3:0] settle_q;
  logic flagShown_q;
  logic line_q;
  logic rxMeta_q;
  logic rxSync_q;
  ast_state_t state_q;
  ast_state_t state_d;
  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic dataWrite;
  logic mapped;
  logic txActive;
  logic flagTrue;
  logic bitTick;
  logic loadShifter;
  logic shiftBit;
  logic restartBaud;
  logic lineBit;
  logic [3:0] lastBit;
  logic [31:0] readValue;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Shared by the write path, read mux and error answer
  function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addrHit = (a == ADDR_W'(ofs));
  endfunction

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAccess = accessPhase && pwrite;
  assign dataWrite = wrAccess && addrHit(paddr, OFS_DATA);
  assign mapped = addrHit(paddr, OFS_CTRL) || addrHit(paddr, OFS_STATUS)
    || addrHit(paddr, OFS_DATA) || addrHit(paddr, OFS_BAUD)
    || addrHit(paddr, OFS_IRQEN);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Writes land only at the access edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= CTRL_RESET;
    else if (wrAccess && addrHit(paddr, OFS_CTRL))
      ctrl_q <= pwdata[CTRL_W-1:0];
  end

  // One divisor pair serves both directions
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_q <= BAUD_RESET;
    else if (wrAccess && addrHit(paddr, OFS_BAUD))
      baud_q <= pwdata[15:0]; // [R5]
  end

  // Interrupt enables never touch the flag itself
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqEn_q <= IRQEN_RESET;
    else if (wrAccess && addrHit(paddr, OFS_IRQEN))
      irqEn_q <= pwdata[IRQEN_W-1:0];
  end

  assign baudDivisor = baud_q; // [R5]
  assign nineBitSelect = ctrl_q[CTRL_NINE_BIT]; // [R5]

  // All three conditions gate the async transmitter
  assign txActive = ctrl_q[CTRL_TX_EN] && !ctrl_q[CTRL_CLOCKED]
    && ctrl_q[CTRL_PORT_EN]; // [R8]

  // ------------------------------------------------------------
  // Holding register
  // ------------------------------------------------------------
  // Ninth bit and length are taken from control at the write,
  // so software must set them first; parity is software's job
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      holdData_q <= '0;
      charNine_q <= 1'b0;
    end
    else if (dataWrite)
    begin
      holdData_q <= {ctrl_q[CTRL_NINTH], pwdata[7:0]}; // [R19] [R6]
      charNine_q <= ctrl_q[CTRL_NINE_BIT]; // [R19]
    end
  end

  // A write in the load cycle keeps the new character pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      holdFull_q <= 1'b0;
    else if (dataWrite)
      holdFull_q <= 1'b1; // [R11]
    else if (!ctrl_q[CTRL_TX_EN])
      holdFull_q <= 1'b0;
    else if (loadShifter)
      holdFull_q <= 1'b0; // [R12]
  end

  // ------------------------------------------------------------
  // Empty flag
  // ------------------------------------------------------------
  // Flag is pure state, no register bit stores it
  assign flagTrue = ctrl_q[CTRL_TX_EN] && !holdFull_q; // [R13] [R14] [R16]

  // Settle window after a data write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_q <= '0;
    else if (dataWrite)
      settle_q <= SETTLE_LOAD; // [R15]
    else if (settle_q != '0)
      settle_q <= settle_q - 1'b1;
  end

  // Shown flag freezes during the window; polling too early
  // reads the stale value, matching software expectations
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flagShown_q <= 1'b0;
    else if (settle_q == '0 && !dataWrite)
      flagShown_q <= flagTrue; // [R15] [R13] [R14]
  end

  // Raised only with the flag and all three enables
  assign transmitEmptyIrq = flagShown_q && irqEn_q[IRQEN_TX]
    && irqEn_q[IRQEN_PERIPH] && irqEn_q[IRQEN_GLOBAL]; // [R17]

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  assign lastBit = shiftNine_q ? LAST_BIT_9 : LAST_BIT_8; // [R2] [R19]

  // Load from idle, or right at the end of a stop bit
  assign loadShifter = txActive && holdFull_q
    && ((state_q == AST_IDLE) || (state_q == AST_STOP && bitTick)); // [R11] [R12]
  // Shifting on the start tick too puts each data bit out on its own tick
  assign shiftBit = bitTick && ((state_q == AST_START) || (state_q == AST_DATA)); // [R4]
  assign restartBaud = (state_q == AST_IDLE); // [R3]

  // Next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      AST_IDLE:
      begin
        if (loadShifter)
          state_d = AST_START; // [R11]
      end
      AST_START:
      begin
        if (bitTick)
          state_d = AST_DATA; // [R2]
      end
      AST_DATA:
      begin
        if (bitTick && bitCnt_q == lastBit)
          state_d = AST_STOP; // [R2]
      end
      AST_STOP:
      begin
        if (loadShifter)
          state_d = AST_START; // [R12]
        else if (bitTick)
          state_d = AST_IDLE; // [R23]
      end
    endcase
    if (!txActive)
      state_d = AST_IDLE; // [R8]
  end

  // Disabling aborts a frame in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= AST_IDLE;
    else
      state_q <= state_d;
  end

  // Data bit counter and frame length
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitCnt_q <= '0;
      shiftNine_q <= 1'b0;
    end
    else if (loadShifter)
    begin
      bitCnt_q <= '0;
      shiftNine_q <= charNine_q; // [R19]
    end
    else if (shiftBit && state_q == AST_DATA)
    begin
      bitCnt_q <= bitCnt_q + 1'b1;
    end
  end

  // Registered line: start space, data, one stop mark, idle mark
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      line_q <= 1'b1;
    else
    begin
      unique case (state_d)
        AST_IDLE: line_q <= 1'b1; // [R1] [R23]
        AST_START: line_q <= 1'b0; // [R2]
        AST_DATA: line_q <= shiftBit ? lineBit : line_q; // [R3] [R4]
        AST_STOP: line_q <= 1'b1; // [R2] [R23]
      endcase
    end
  end

  // ------------------------------------------------------------
  // Baud generator and shifter
  // ------------------------------------------------------------
  ast_baud_gen #(
    .DIV_W(16),
    .PRE_W(5)
  ) u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .restart(restartBaud),
    .wideSel(ctrl_q[CTRL_WIDE_DIV]),
    .highSpeed(ctrl_q[CTRL_HIGH_SPEED]),
    .divisor(baud_q),
    .bitTick(bitTick)
  );

  ast_shifter #(
    .W(CHAR_W)
  ) u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .load(loadShifter),
    .shift(shiftBit),
    .loadData(holdData_q),
    .lineBit(lineBit)
  );

  // ------------------------------------------------------------
  // Pin ownership
  // ------------------------------------------------------------
  // Port enable takes the transmit pin whatever the direction
  assign transmitPinOe = ctrl_q[CTRL_PORT_EN] || !transmitPinDirection; // [R9]
  assign transmitPinOut = ctrl_q[CTRL_PORT_EN] ? line_q : transmitPinLatch; // [R9]

  // Receive pin becomes input and its latch is blocked
  assign receivePinOe = !ctrl_q[CTRL_PORT_EN] && !receivePinDirection; // [R10]
  assign receivePinOut = ctrl_q[CTRL_PORT_EN] ? 1'b0 : receivePinLatch; // [R10]

  // Two-stage synchroniser for the port read of the pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end
    else
    begin
      rxMeta_q <= receivePinIn;
      rxSync_q <= rxMeta_q;
    end
  end

  assign receivePinLevel = rxSync_q; // [R10]

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Read mux; unmapped reads return zero
  always_comb
  begin
    readValue = '0;
    if (addrHit(paddr, OFS_CTRL))
      readValue[CTRL_W-1:0] = ctrl_q;
    else if (addrHit(paddr, OFS_STATUS))
    begin
      readValue[STAT_EMPTY_FLAG] = flagShown_q; // [R16]
      readValue[STAT_SHIFT_EMPTY] = (state_q == AST_IDLE); // [R18]
      readValue[STAT_IRQ] = transmitEmptyIrq;
    end
    else if (addrHit(paddr, OFS_DATA))
      readValue[CHAR_W-1:0] = holdData_q;
    else if (addrHit(paddr, OFS_BAUD))
      readValue[15:0] = baud_q;
    else if (addrHit(paddr, OFS_IRQEN))
      readValue[IRQEN_W-1:0] = irqEn_q;
  end

  // Captured in setup, so read data comes from a flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (setupPhase)
      prdata <= readValue;
  end
endmodule
`default_nettype wire

// *** design/ast_pkg.sv ***
// Shared constants, register map and types of the serial transmitter
package ast_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_IRQEN = 8'h10;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_CLOCKED = 1;
  localparam int CTRL_NINE_BIT = 2;
  localparam int CTRL_NINTH = 3;
  localparam int CTRL_PORT_EN = 4;
  localparam int CTRL_HIGH_SPEED = 5;
  localparam int CTRL_WIDE_DIV = 6;
  localparam int CTRL_W = 7;
  localparam int STAT_EMPTY_FLAG = 0;
  localparam int STAT_SHIFT_EMPTY = 1;
  localparam int STAT_IRQ = 2;
  localparam int IRQEN_TX = 0;
  localparam int IRQEN_PERIPH = 1;
  localparam int IRQEN_GLOBAL = 2;
  localparam int IRQEN_W = 3;
  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [2:0] IRQEN_RESET = 3'h0;
  localparam int PRESCALE_LOW = 16;
  localparam int PRESCALE_HIGH = 4;
  localparam int CLK_NS = 25;
  localparam int INSTR_CYCLE_NS = 100;
  localparam int INSTR_CLKS = (INSTR_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLAG_SETTLE_INSTR = 2;
  localparam int FLAG_SETTLE_CLKS = FLAG_SETTLE_INSTR * INSTR_CLKS;
  localparam logic [3:0] SETTLE_LOAD = 4'(FLAG_SETTLE_CLKS);
  localparam int CHAR_W = 9;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  typedef enum logic [1:0] {AST_IDLE, AST_START, AST_DATA, AST_STOP} ast_state_t;
endpackage

// *** design/ast_baud_gen.sv ***
// Baud rate generator: divisor counter and prescaler giving one pulse per bit
`timescale 1ns/10ps
`default_nettype none
module ast_baud_gen
  import ast_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int PRE_W = 5
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic wideSel,
  input wire logic highSpeed,
  input wire logic [DIV_W-1:0] divisor,
  output logic bitTick
);
  logic [DIV_W-1:0] divCnt_q;
  logic [PRE_W-1:0] preCnt_q;
  logic [DIV_W-1:0] divEff;
  logic [PRE_W-1:0] preLast;
  logic divTick;

  // Narrow mode ignores the upper divisor byte
  assign divEff = wideSel ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]}; // [R7]
  assign preLast = highSpeed ? PRE_W'(PRESCALE_HIGH - 1) : PRE_W'(PRESCALE_LOW - 1);
  assign divTick = (divCnt_q == '0);
  assign bitTick = divTick && (preCnt_q == preLast); // [R3]

  // Restart aligns a fresh frame to a whole bit period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_q <= '0;
      preCnt_q <= '0;
    end
    else if (restart)
    begin
      divCnt_q <= divEff;
      preCnt_q <= '0;
    end
    else if (divTick)
    begin
      divCnt_q <= divEff;
      preCnt_q <= (preCnt_q == preLast) ? '0 : preCnt_q + 1'b1;
    end
    else
    begin
      divCnt_q <= divCnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** design/ast_shifter.sv ***
// Character shift register, emits the low bit first
`timescale 1ns/10ps
`default_nettype none
module ast_shifter
  import ast_pkg::*;
#(
  parameter int W = CHAR_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic shift,
  input wire logic [W-1:0] loadData,
  output logic lineBit
);
  logic [W-1:0] shift_q;

  // Load wins over shift; ones fill from the top
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_q <= '1;
    else if (load)
      shift_q <= loadData;
    else if (shift)
      shift_q <= {1'b1, shift_q[W-1:1]}; // [R4]
  end

  assign lineBit = shift_q[0]; // [R4]
endmodule
`default_nettype wire

// *** test/ast_serial_tx_asserts.sv ***
// Checker of pin ownership, bit timing and register mirrors
`timescale 1ns/10ps
`default_nettype none
module ast_serial_tx_asserts
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic transmitPinLatch,
  input wire logic transmitPinDirection,
  input wire logic transmitPinOut,
  input wire logic transmitPinOe,
  input wire logic receivePinIn,
  input wire logic receivePinLatch,
  input wire logic receivePinDirection,
  input wire logic receivePinOut,
  input wire logic receivePinOe,
  input wire logic receivePinLevel,
  input wire logic [15:0] baudDivisor,
  input wire logic nineBitSelect,
  input wire logic transmitEmptyIrq
);
  // --------
  // Shadow of software writes
  // --------
  logic [6:0] ctrl_q;
  logic [2:0] irqEn_q;
  logic [21:0] runLen_q;
  wire logic wrHit = psel && penable && pwrite;
  wire logic [15:0] wrLow = pwdata[15:0];
  wire logic portEn = ctrl_q[CTRL_PORT_EN];
  wire logic txActive = portEn && ctrl_q[CTRL_TX_EN] && !ctrl_q[CTRL_CLOCKED];
  wire logic [15:0] divUsed = ctrl_q[CTRL_WIDE_DIV] ? baudDivisor : {8'h00, baudDivisor[7:0]};
  wire logic [21:0] period = (22'(divUsed) + 22'h1)
    * (ctrl_q[CTRL_HIGH_SPEED] ? 22'(PRESCALE_HIGH) : 22'(PRESCALE_LOW));
  // Writes land at the same edge the design takes them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= 7'h00;
      irqEn_q <= 3'h0;
    end
    else if (wrHit)
    begin
      if (paddr == OFS_CTRL)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == OFS_IRQEN)
        irqEn_q <= pwdata[IRQEN_W-1:0];
    end
  end
  // Length of the current line level; wraps harmlessly on long idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      runLen_q <= 22'h0;
    else
      runLen_q <= $changed(transmitPinOut) ? 22'h1 : runLen_q + 22'h1;
  end
  // --------
  // Assertions
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_tx_owned:
    assert property (portEn |-> transmitPinOe) else $error("tx pin not driven");
  a_pin_released:
    assert property (!portEn |-> transmitPinOut == transmitPinLatch
      && transmitPinOe == !transmitPinDirection) else $error("tx pin not released");
  a_rx_input:
    assert property (receivePinOe == (!portEn && !receivePinDirection)
      && receivePinOut == (!portEn && receivePinLatch)) else $error("rx pin not input");
  a_rx_sync:
    assert property ($stable(receivePinIn) [*3] |=> receivePinLevel == $past(receivePinIn))
      else $error("rx level not passed");
  a_idle_mark:
    assert property ((portEn && !txActive) [*3] |-> transmitPinOut)
      else $error("line not at mark");
  a_bit_time:
    assert property ($rose(transmitPinOut) && portEn && $past(portEn) |->
      runLen_q >= period && runLen_q % period == 22'h0) else $error("bit length wrong");
  a_baud_mirror:
    assert property (wrHit && paddr == OFS_BAUD |=> baudDivisor == $past(wrLow))
      else $error("divisor not kept");
  a_nine_mirror:
    assert property (nineBitSelect == ctrl_q[CTRL_NINE_BIT]) else $error("nine bit lost");
  a_irq_gate:
    assert property (transmitEmptyIrq |-> irqEn_q == 3'h7) else $error("irq without enables");
  c_frame: cover property ($fell(transmitPinOut) && portEn);
  c_nine: cover property (nineBitSelect && $fell(transmitPinOut));
  c_irq: cover property (transmitEmptyIrq);
endmodule
bind ast_serial_tx ast_serial_tx_asserts i_chk (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .transmitPinLatch, .transmitPinDirection, .transmitPinOut,
  .transmitPinOe, .receivePinIn, .receivePinLatch, .receivePinDirection, .receivePinOut,
  .receivePinOe, .receivePinLevel, .baudDivisor, .nineBitSelect, .transmitEmptyIrq);
`default_nettype wire

// *** test/ast_rx_model.sv ***
// Terminal model: decodes frames from the transmit line
`timescale 1ns/10ps
`default_nettype none
module ast_rx_model
(
  input wire logic clk,
  input wire logic line,
  input wire logic nine,
  input wire logic [15:0] bitClks,
  output logic [8:0] rxChar,
  output logic [7:0] rxCnt,
  output logic frameErr
);
  logic [8:0] d;
  int nb;
  // Mid-bit sampling, so half a bit of drift is tolerated
  initial
  begin
    rxCnt = 8'h00;
    rxChar = 9'h000;
    frameErr = 1'b0;
    forever
    begin
      @(posedge clk);
      if (line === 1'b0)
      begin
        nb = nine ? 9 : 8;
        d = 9'h000;
        repeat (bitClks / 2) @(posedge clk);
        if (line !== 1'b0)
          frameErr <= 1'b1;
        for (int i = 0; i < nb; i++)
        begin
          repeat (bitClks) @(posedge clk);
          d[i] = line;
        end
        repeat (bitClks) @(posedge clk);
        if (line !== 1'b1)
          frameErr <= 1'b1;
        rxChar <= d;
        rxCnt <= rxCnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb_ast_serial_tx.sv ***
// Self-checking bench of the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module tb_ast_serial_tx
  import ast_pkg::*;
;
  // --------
  // Signals and instances
  // --------
  localparam int BITC = 2 * PRESCALE_HIGH;
  logic clk, rst_n, psel, penable, pwrite, pslverr, pready, lastErr, frameErr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic transmitPinLatch, transmitPinDirection, transmitPinOut, transmitPinOe;
  logic receivePinIn, receivePinLatch, receivePinDirection, receivePinOut, receivePinOe;
  logic receivePinLevel, nineBitSelect, transmitEmptyIrq;
  logic [15:0] baudDivisor, bitc;
  logic [8:0] rxChar;
  logic [7:0] rxCnt, seen;
  int errors, comparisons, gap;
  wire logic txWire = transmitPinOe ? transmitPinOut : 1'b1;
  // Clock at 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ast_serial_tx i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .transmitPinLatch, .transmitPinDirection, .transmitPinOut,
    .transmitPinOe, .receivePinIn, .receivePinLatch, .receivePinDirection, .receivePinOut,
    .receivePinOe, .receivePinLevel, .baudDivisor, .nineBitSelect, .transmitEmptyIrq);
  ast_rx_model i_term (.clk, .line(txWire), .nine(nineBitSelect), .bitClks(bitc),
    .rxChar, .rxCnt, .frameErr);
  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer; psel drops a cycle between calls
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  // Waits for the next decoded character, counting cycles
  task automatic expRx(input logic [8:0] e);
    gap = 0;
    while (rxCnt === seen && gap < 12000)
    begin
      @(posedge clk);
      gap++;
    end
    // Exactly one character per frame; a timeout fails here
    chk({24'h0, rxCnt}, {24'h0, seen + 8'h01});
    seen = rxCnt;
    chk({23'h0, rxChar}, {23'h0, e});
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard; the wide-divisor frame alone takes over ten thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
  // --------
  // Sequence
  // --------
  initial
  begin
    errors = 0;
    comparisons = 0;
    seen = 8'h00;
    bitc = 16'(BITC);
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    transmitPinLatch = 1'b1;
    transmitPinDirection = 1'b1;
    receivePinIn = 1'b1;
    receivePinLatch = 1'b1;
    receivePinDirection = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(OFS_STATUS, 32'h0000_0002);
    rdchk(OFS_CTRL, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_FFFF);
    chk({31'h0, lastErr}, 32'h0000_0001);
    // Low byte only: divisor 1, fast prescale
    wr(OFS_BAUD, 32'h0000_0101);
    wr(OFS_CTRL, 32'h0000_0030);
    rdchk(OFS_STATUS, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0031);
    rdchk(OFS_STATUS, 32'h0000_0003);
    wr(OFS_STATUS, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0003);
    // One character sending, a second queued behind it
    wr(OFS_DATA, 32'h0000_00A5);
    repeat (10) @(posedge clk);
    rdchk(OFS_STATUS, 32'h0000_0001);
    wr(OFS_DATA, 32'h0000_003C);
    rdchk(OFS_STATUS, 32'h0000_0001);
    repeat (10) @(posedge clk);
    rdchk(OFS_STATUS, 32'h0000_0000);
    expRx(9'h0A5);
    expRx(9'h03C);
    chk(gap, 10 * BITC);
    repeat (10) @(posedge clk);
    rdchk(OFS_STATUS, 32'h0000_0003);
    // Address character in nine-bit mode
    wr(OFS_CTRL, 32'h0000_003D);
    wr(OFS_DATA, 32'h0000_0055);
    expRx(9'h155);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL, 32'h0000_0031);
    // Interrupt raised, masked by global enable, then dropped
    wr(OFS_IRQEN, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk({31'h0, transmitEmptyIrq}, 32'h0000_0001);
    wr(OFS_IRQEN, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({31'h0, transmitEmptyIrq}, 32'h0000_0000);
    wr(OFS_IRQEN, 32'h0000_0000);
    // Slow prescale with the high byte ignored, then the wide divisor 256
    bitc <= 16'(PRESCALE_LOW);
    wr(OFS_BAUD, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0011);
    wr(OFS_DATA, 32'h0000_0096);
    expRx(9'h096);
    repeat (20) @(posedge clk);
    bitc <= 16'(257 * PRESCALE_HIGH);
    wr(OFS_CTRL, 32'h0000_0071);
    wr(OFS_DATA, 32'h0000_0069);
    expRx(9'h069);
    // Clocked mode blocks sending; clearing enable drops the pending char
    wr(OFS_CTRL, 32'h0000_0033);
    wr(OFS_DATA, 32'h0000_000F);
    repeat (150) @(posedge clk);
    chk({24'h0, rxCnt}, {24'h0, seen});
    wr(OFS_CTRL, 32'h0000_0030);
    wr(OFS_CTRL, 32'h0000_0031);
    repeat (150) @(posedge clk);
    chk({24'h0, rxCnt}, {24'h0, seen});
    // Latch and direction ignored while the port owns the pins
    transmitPinLatch <= 1'b0;
    transmitPinDirection <= 1'b0;
    receivePinDirection <= 1'b0;
    receivePinIn <= 1'b0;
    repeat (4) @(posedge clk);
    chk({30'h0, txWire, receivePinLevel}, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({30'h0, transmitPinOut, transmitPinOe}, 32'h0000_0001);
    chk({31'h0, frameErr}, 32'h0000_0000);
    close_out;
  end
endmodule
`default_nettype wire
